/* inc/pcgb_pkg.sv */
package pcgb_pkg;
  // ==========================================================================
  // register map (byte addresses within the system control block)
  localparam logic [11:0] RUN_GATE_OFS      = 12'h104;
  localparam logic [11:0] SLEEP_GATE_OFS    = 12'h114;
  localparam logic [11:0] DEEP_GATE_OFS     = 12'h124;
  localparam logic [11:0] CLK_CFG_OFS       = 12'h060;
  localparam logic [11:0] POWER_MODE_OFS    = 12'h200;
  localparam logic [11:0] IRQ_STATUS_OFS    = 12'h204;
  localparam logic [11:0] IRQ_MASK_OFS      = 12'h208;
  localparam logic [11:0] FAULT_UNIT_OFS    = 12'h20C;
  // ==========================================================================
  // field layout
  localparam int          NUM_UNITS         = 10;
  localparam logic [31:0] GATE_WRITABLE     = 32'h070F0013;
  localparam logic [31:0] GATE_RESET        = 32'h00000000;
  localparam int          AUTO_GATING_BIT   = 27;
  localparam logic [31:0] CLK_CFG_WRITABLE  = 32'h08000000;
  localparam logic [31:0] CLK_CFG_RESET     = 32'h00000000;
  localparam int          IRQ_BITS          = 2;
  localparam int          IRQ_FAULT_BIT     = 0;
  localparam int          IRQ_MODE_BIT      = 1;
  localparam logic [1:0]  IRQ_RESET         = 2'h0;
  // register bit position of each gated unit, in unit index order
  localparam int          UNIT_BIT [NUM_UNITS] = '{16, 17, 18, 19, 4, 0, 1, 24, 25, 26};
  // ==========================================================================
  // power modes
  typedef enum logic [1:0]
  {
    PM_RUN   = 2'h0,
    PM_SLEEP = 2'h1,
    PM_DEEP  = 2'h3
  } pcgb_mode_type;
  // bus answer sequencing
  typedef enum logic [1:0]
  {
    BS_IDLE = 2'h0,
    BS_DONE = 2'h1
  } pcgb_bus_type;
endpackage

/* rtl/pcgb_gate_cell.sv */
module pcgb_gate_cell
  import pcgb_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // control
  input  wire logic enable,
  // gated outputs
  output logic      gated_clk,
  output logic      enable_ff
);
  // ==========================================================================
  // latch-free gate: enable is retimed on the falling edge so it only moves
  // while clk is low, hence no shortened high phase reaches the unit
  always_ff @(negedge clk)
  begin
    if (reset)
      enable_ff <= 1'b0;
    else
      enable_ff <= enable;
  end

  assign gated_clk = clk & enable_ff;
endmodule

/* rtl/pcgb_fault_check.sv */
module pcgb_fault_check
  import pcgb_pkg::*;
#(
  parameter int UNITS = NUM_UNITS
)
(
  // unit access observation
  input  wire logic [UNITS-1:0] unit_access,
  input  wire logic [UNITS-1:0] unit_clock_on,
  // fault answer
  output logic                  fault,
  output logic [UNITS-1:0]      fault_units
);
  // ==========================================================================
  // any access to a unit whose gate is off is refused with a bus fault
  assign fault_units = unit_access & ~unit_clock_on;
  assign fault       = |fault_units;
endmodule

/* rtl/pcgb_top.sv */
// The Avalon-MM slave port was left to the implementer.
module pcgb_top
  import pcgb_pkg::*;
(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset,
  // avalon-mm slave
  input  wire logic [11:0]              address,
  input  wire logic                     read,
  input  wire logic                     write,
  input  wire logic [31:0]              writedata,
  input  wire logic [3:0]               byteenable,
  output logic [31:0]                   readdata,
  output logic [1:0]                    response,
  output logic                          waitrequest,
  // power state from the power manager
  input  wire pcgb_pkg::pcgb_mode_type  power_mode,
  // peripheral access observation
  input  wire logic [pcgb_pkg::NUM_UNITS-1:0] unit_access,
  output logic                          unit_bus_fault,
  // gated clocks and gate levels
  output logic                          gp_counter_unit0_gate,
  output logic                          gp_counter_unit1_gate,
  output logic                          gp_counter_unit2_gate,
  output logic                          gp_counter_unit3_gate,
  output logic                          sync_serial_port0_gate,
  output logic                          async_serial_port0_gate,
  output logic                          async_serial_port1_gate,
  output logic                          analog_cmp0_gate,
  output logic                          analog_cmp1_gate,
  output logic                          analog_cmp2_gate,
  output logic [pcgb_pkg::NUM_UNITS-1:0] unit_clk,
  // interrupt
  output logic                          irq
);
  import pcgb_pkg::*;

  // avalon response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // helpers
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be,
                                              input logic [31:0] writable);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
      m[i*8 +: 8] = {8{be[i]}};
    m = m & writable;
    return (old_v & ~m) | (new_v & m);
  endfunction

  function automatic logic [NUM_UNITS-1:0] unit_bits(input logic [31:0] reg_v);
    logic [NUM_UNITS-1:0] u;
    u = '0;
    for (int i = 0; i < NUM_UNITS; i++)
      u[i] = reg_v[UNIT_BIT[i]];
    return u;
  endfunction

  // ==========================================================================
  // registers
  logic [31:0]          run_peripheral_gate_1_ff;
  logic [31:0]          sleep_peripheral_gate_1_ff;
  logic [31:0]          deep_sleep_peripheral_gate_1_ff;
  logic [31:0]          run_mode_clock_config_ff;
  logic [IRQ_BITS-1:0]  irq_status_ff;
  logic [IRQ_BITS-1:0]  irq_mask_ff;
  logic [NUM_UNITS-1:0] fault_units_ff;
  pcgb_mode_type        mode_ff;
  pcgb_bus_type         bus_state_ff;
  pcgb_bus_type         nxt_bus_state;
  logic [31:0]          readdata_ff;
  logic [1:0]           response_ff;

  logic                 auto_sleep_gating_enable;
  logic                 wr_take;
  logic                 rd_take;
  logic [31:0]          active_gate;
  logic [NUM_UNITS-1:0] gate_level;
  logic [NUM_UNITS-1:0] gate_level_ff;
  logic                 fault;
  logic [NUM_UNITS-1:0] fault_units;
  logic [IRQ_BITS-1:0]  irq_event;
  logic [31:0]          rd_value;
  logic                 rd_hit;
  logic                 wr_run;
  logic                 wr_sleep;
  logic                 wr_deep;
  logic                 wr_cfg;
  logic                 wr_mask;
  logic                 wr_status;
  logic                 irq_ff;

  assign auto_sleep_gating_enable = run_mode_clock_config_ff[AUTO_GATING_BIT];

  // ==========================================================================
  // bus handshake: every access is answered one cycle after it is seen
  always_comb
  begin
    case (bus_state_ff)
      BS_IDLE: nxt_bus_state = (read || write) ? BS_DONE : BS_IDLE;
      BS_DONE: nxt_bus_state = BS_IDLE;
      default: nxt_bus_state = BS_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      bus_state_ff <= BS_IDLE;
    else
      bus_state_ff <= nxt_bus_state;
  end

  // writes taken on the cycle the answer is presented, so they land exactly once; reads taken in the request cycle
  assign waitrequest = (read || write) && (bus_state_ff != BS_DONE);
  assign wr_take     = write && (bus_state_ff == BS_DONE);
  assign rd_take     = read && (bus_state_ff == BS_IDLE);

  // ==========================================================================
  // write strobes, raised only in the answer cycle so a write lands once
  always_comb
  begin
    wr_run    = 1'b0;
    wr_sleep  = 1'b0;
    wr_deep   = 1'b0;
    wr_cfg    = 1'b0;
    wr_mask   = 1'b0;
    wr_status = 1'b0;
    case (address)
      RUN_GATE_OFS:   wr_run    = wr_take;
      SLEEP_GATE_OFS: wr_sleep  = wr_take;
      DEEP_GATE_OFS:  wr_deep   = wr_take;
      CLK_CFG_OFS:    wr_cfg    = wr_take;
      IRQ_MASK_OFS:   wr_mask   = wr_take && byteenable[0];
      IRQ_STATUS_OFS: wr_status = wr_take && byteenable[0];
      default:        wr_run    = 1'b0;
    endcase
  end

  // ==========================================================================
  // gate registers
  always_ff @(posedge clk)
  begin
    if (reset)
      run_peripheral_gate_1_ff <= GATE_RESET;
    else if (wr_run)
      run_peripheral_gate_1_ff <= merge_bytes(run_peripheral_gate_1_ff, writedata,
                                              byteenable, GATE_WRITABLE);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      sleep_peripheral_gate_1_ff <= GATE_RESET;
    else if (wr_sleep)
      sleep_peripheral_gate_1_ff <= merge_bytes(sleep_peripheral_gate_1_ff, writedata,
                                                byteenable, GATE_WRITABLE);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      deep_sleep_peripheral_gate_1_ff <= GATE_RESET;
    else if (wr_deep)
      deep_sleep_peripheral_gate_1_ff <= merge_bytes(deep_sleep_peripheral_gate_1_ff,
                                                     writedata, byteenable,
                                                     GATE_WRITABLE);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      run_mode_clock_config_ff <= CLK_CFG_RESET;
    else if (wr_cfg)
      run_mode_clock_config_ff <= merge_bytes(run_mode_clock_config_ff, writedata,
                                              byteenable, CLK_CFG_WRITABLE);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      irq_mask_ff <= IRQ_RESET;
    else if (wr_mask)
      irq_mask_ff <= writedata[IRQ_BITS-1:0];
  end

  // ==========================================================================
  // power mode selection
  // one cycle late on purpose: gate path sees one stable mode; the event bit compares it with the live power_mode
  always_ff @(posedge clk)
  begin
    if (reset)
      mode_ff <= PM_RUN;
    else
      mode_ff <= power_mode;
  end

  // without auto gating the run copy stays in force in every mode
  always_comb
  begin
    case (mode_ff)
      PM_RUN:   active_gate = run_peripheral_gate_1_ff;
      PM_SLEEP: active_gate = auto_sleep_gating_enable ? sleep_peripheral_gate_1_ff
                                                       : run_peripheral_gate_1_ff;
      PM_DEEP:  active_gate = auto_sleep_gating_enable ? deep_sleep_peripheral_gate_1_ff
                                                       : run_peripheral_gate_1_ff;
      default:  active_gate = run_peripheral_gate_1_ff;
    endcase
  end

  assign gate_level = unit_bits(active_gate);

  always_ff @(posedge clk)
  begin
    if (reset)
      gate_level_ff <= '0;
    else
      gate_level_ff <= gate_level;
  end

  // ==========================================================================
  // glitch-free clock gates
  for (genvar g = 0; g < NUM_UNITS; g++)
  begin : gen_gate
    pcgb_gate_cell u_cell
    (
      .clk       (clk),
      .reset     (reset),
      .enable    (gate_level_ff[g]),
      .gated_clk (unit_clk[g]),
      .enable_ff ()
    );
  end

  assign gp_counter_unit0_gate   = gate_level_ff[0];
  assign gp_counter_unit1_gate   = gate_level_ff[1];
  assign gp_counter_unit2_gate   = gate_level_ff[2];
  assign gp_counter_unit3_gate   = gate_level_ff[3];
  assign sync_serial_port0_gate  = gate_level_ff[4];
  assign async_serial_port0_gate = gate_level_ff[5];
  assign async_serial_port1_gate = gate_level_ff[6];
  assign analog_cmp0_gate        = gate_level_ff[7];
  assign analog_cmp1_gate        = gate_level_ff[8];
  assign analog_cmp2_gate        = gate_level_ff[9];

  // ==========================================================================
  // bus fault on access to a gated-off unit
  pcgb_fault_check #(.UNITS(NUM_UNITS)) u_fault
  (
    .unit_access   (unit_access),
    .unit_clock_on (gate_level_ff),
    .fault         (fault),
    .fault_units   (fault_units)
  );

  assign unit_bus_fault = fault;

  always_ff @(posedge clk)
  begin
    if (reset)
      fault_units_ff <= '0;
    else if (fault)
      fault_units_ff <= fault_units;
  end

  // ==========================================================================
  // interrupt status: set wins over write-one-to-clear
  assign irq_event[IRQ_FAULT_BIT] = fault;
  assign irq_event[IRQ_MODE_BIT]  = (mode_ff != power_mode);

  always_ff @(posedge clk)
  begin
    if (reset)
      irq_status_ff <= IRQ_RESET;
    else if (wr_status)
      irq_status_ff <= (irq_status_ff & ~writedata[IRQ_BITS-1:0]) | irq_event;
    else
      irq_status_ff <= irq_status_ff | irq_event;
  end

  // registered so the pin never shows a pulse while mask and status move apart
  always_ff @(posedge clk)
  begin
    if (reset)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(irq_status_ff & irq_mask_ff);
  end

  assign irq = irq_ff;

  // ==========================================================================
  // read mux; reserved bits never stored so they read zero
  always_comb
  begin
    rd_hit   = 1'b1;
    rd_value = '0;
    case (address)
      RUN_GATE_OFS:   rd_value = run_peripheral_gate_1_ff;
      SLEEP_GATE_OFS: rd_value = sleep_peripheral_gate_1_ff;
      DEEP_GATE_OFS:  rd_value = deep_sleep_peripheral_gate_1_ff;
      CLK_CFG_OFS:    rd_value = run_mode_clock_config_ff;
      POWER_MODE_OFS: rd_value = {30'h0, mode_ff};
      IRQ_STATUS_OFS: rd_value = {30'h0, irq_status_ff};
      IRQ_MASK_OFS:   rd_value = {30'h0, irq_mask_ff};
      FAULT_UNIT_OFS: rd_value = {22'h0, fault_units_ff};
      default:        rd_hit   = 1'b0;
    endcase
  end

  // captured on the request edge and held through the answer cycle
  always_ff @(posedge clk)
  begin
    if (reset)
      readdata_ff <= '0;
    else if (rd_take)
      readdata_ff <= rd_value;
  end

  // unmapped addresses answer slaveerror (2'b10), reads give zero
  always_ff @(posedge clk)
  begin
    if (reset)
      response_ff <= RESP_OKAY;
    else if (bus_state_ff == BS_IDLE && (read || write))
      response_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
  end

  assign readdata = readdata_ff;
  assign response = response_ff;
endmodule

/* testbench/pcgb_top_sva.sv */
module pcgb_top_sva
  import pcgb_pkg::*;
(
  // clock, reset and bus
  input wire logic                 clk,
  input wire logic                 reset,
  input wire logic [11:0]          address,
  input wire logic                 read,
  input wire logic                 write,
  input wire logic [31:0]          readdata,
  input wire logic [1:0]           response,
  input wire logic                 waitrequest,
  // units
  input wire logic [NUM_UNITS-1:0] unit_access,
  input wire logic                 unit_bus_fault,
  input wire logic                 gp_counter_unit0_gate,
  input wire logic                 gp_counter_unit1_gate,
  input wire logic                 gp_counter_unit2_gate,
  input wire logic                 gp_counter_unit3_gate,
  input wire logic                 sync_serial_port0_gate,
  input wire logic                 async_serial_port0_gate,
  input wire logic                 async_serial_port1_gate,
  input wire logic                 analog_cmp0_gate,
  input wire logic                 analog_cmp1_gate,
  input wire logic                 analog_cmp2_gate,
  input wire logic [NUM_UNITS-1:0] unit_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NUM_UNITS-1:0] gv;
  logic                 rd_ok;
  logic                 gate_ofs;
  assign gv = {analog_cmp2_gate, analog_cmp1_gate, analog_cmp0_gate,
               async_serial_port1_gate, async_serial_port0_gate, sync_serial_port0_gate,
               gp_counter_unit3_gate, gp_counter_unit2_gate, gp_counter_unit1_gate,
               gp_counter_unit0_gate};
  assign rd_ok = read && !waitrequest;
  assign gate_ofs = address == RUN_GATE_OFS || address == SLEEP_GATE_OFS ||
                    address == DEEP_GATE_OFS;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ====================
  // assertions
  fault_map_a: assert property (unit_bus_fault == |(unit_access & ~gv))
    else $error("bus fault does not match gate state");
  gate_reset_a: assert property (disable iff (1'b0) reset |=> gv == '0)
    else $error("gate left set after reset");
  one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered after one wait cycle");
  mapped_ok_a: assert property (rd_ok && gate_ofs |-> response == 2'h0)
    else $error("gate register read not answered okay");
  reserved_zero_a: assert property (rd_ok && gate_ofs |-> (readdata & ~GATE_WRITABLE) == '0)
    else $error("reserved gate bits read nonzero");
  unused_pos_a: assert property (rd_ok && gate_ofs |-> readdata[23:20] == 4'h0)
    else $error("unused gate positions read nonzero");
  // sampled on the falling edge, where the gated clock shows its latched enable
  clk_follow_a: assert property (@(negedge clk) disable iff (reset) unit_clk == $past(gv))
    else $error("gated clock disagrees with gate level");
  no_glitch_a: assert property (unit_clk == '0)
    else $error("gated clock high before rising edge");
  cover property (rd_ok && gate_ofs);
  cover property (unit_bus_fault);
  cover property (write && !waitrequest);
endmodule

bind pcgb_top pcgb_top_sva pcgb_top_sva_i (.*);

/* testbench/pcgb_cpu_model.sv */
module pcgb_cpu_model
  import pcgb_pkg::*;
(
  // clock
  input wire logic        clk,
  // avalon-mm master side
  output logic [11:0]     address,
  output logic            read,
  output logic            write,
  output logic [31:0]     writedata,
  output logic [3:0]      byteenable,
  input wire logic [31:0] readdata,
  input wire logic [1:0]  response,
  input wire logic        waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  // byte lanes for the next access; the bench narrows it for lane tests
  logic [3:0]  be_sel = 4'hF;
  initial
  begin
    address = 12'h000;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hF;
  end
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
            output logic [31:0] q, output logic [1:0] r);
    @(posedge clk);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= d;
    byteenable <= be_sel;
    // answer read at the edge itself, before any slave flop moves
    do
      @(posedge clk);
    while (waitrequest);
    q = readdata;
    r = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task rmw(input logic [11:0] a, input logic [31:0] set);
    logic [31:0] q;
    logic [1:0]  r;
    xfer(a, 1'b0, 32'h0, q, r);
    xfer(a, 1'b1, q | set, q, r);
  endtask
endmodule

/* testbench/tb_peripheral_clock_gating_bank1.sv */
module tb_peripheral_clock_gating_bank1;
  timeunit 1ns;
  timeprecision 1ps;
  import pcgb_pkg::*;
  logic clk = 1'b0, reset, read, write, waitrequest, unit_bus_fault, irq, auto_on;
  logic [11:0] address;
  logic [31:0] writedata, readdata, q, rv [3];
  logic [3:0] byteenable;
  logic [1:0] response, r;
  logic [NUM_UNITS-1:0] unit_access, unit_clk, gv;
  pcgb_mode_type power_mode;
  logic [11:0] ofs [3] = '{RUN_GATE_OFS, SLEEP_GATE_OFS, DEEP_GATE_OFS};
  int seed = 79;
  int n_fail = 0;
  int compares = 0;
  pcgb_top dut (.gp_counter_unit0_gate(gv[0]), .gp_counter_unit1_gate(gv[1]),
    .gp_counter_unit2_gate(gv[2]), .gp_counter_unit3_gate(gv[3]),
    .sync_serial_port0_gate(gv[4]), .async_serial_port0_gate(gv[5]),
    .async_serial_port1_gate(gv[6]), .analog_cmp0_gate(gv[7]),
    .analog_cmp1_gate(gv[8]), .analog_cmp2_gate(gv[9]), .*);
  pcgb_cpu_model cpu (.*);
  always #2.5 clk = ~clk;
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task summarize;
    if (n_fail == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  function logic [NUM_UNITS-1:0] exp_g(input pcgb_mode_type m, input logic a);
    logic [31:0] v;
    v = (a && m == PM_SLEEP) ? rv[1] : (a && m == PM_DEEP) ? rv[2] : rv[0];
    for (int i = 0; i < NUM_UNITS; i++)
      exp_g[i] = v[UNIT_BIT[i]];
  endfunction
  // gate latency is two edges; four leaves margin
  task settle;
    repeat (4) @(posedge clk);
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    cpu.xfer(a, 1'b0, 32'h0, q, r);
    chk("readdata", q, e);
    chk("response", {30'h0, r}, {30'h0, er});
  endtask
  task irq_chk(input logic [11:0] a, input logic [31:0] d, input logic e);
    cpu.xfer(a, 1'b1, d, q, r);
    settle;
    chk("irq", {31'h0, irq}, {31'h0, e});
  endtask
  // ====================
  // main sequence
  initial
  begin
    reset = 1'b1;
    power_mode = PM_RUN;
    unit_access = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 3; i++)
      rd_chk(ofs[i], 32'h0, 2'h0);
    chk("gates", {22'h0, gv}, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      for (int i = 0; i < 3; i++)
      begin
        rv[i] = (k == 0) ? 32'hFFFFFFFF : (k == 1) ? 32'h0 : $random(seed);
        cpu.xfer(ofs[i], 1'b1, rv[i], q, r);
        rv[i] = rv[i] & GATE_WRITABLE;
        rd_chk(ofs[i], rv[i], 2'h0);
      end
      auto_on = 1'($random(seed));
      cpu.xfer(CLK_CFG_OFS, 1'b1, 32'h0, q, r);
      if (auto_on)
        cpu.rmw(CLK_CFG_OFS, 32'h08000000);
      // code 2 names no mode and must fall back to the run copy
      for (int m = 0; m < 4; m++)
      begin
        power_mode <= pcgb_mode_type'(m);
        unit_access <= 10'($random(seed));
        settle;
        chk("gates", {22'h0, gv},
            {22'h0, exp_g(power_mode, auto_on)});
        chk("fault", {31'h0, unit_bus_fault},
            {31'h0, |(unit_access & ~exp_g(power_mode, auto_on))});
        rd_chk(POWER_MODE_OFS, m, 2'h0);
      end
    end
    // reset in mid-run must drop every gate that the loop left set
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    settle;
    chk("gates", {22'h0, gv}, 32'h0);
    for (int i = 0; i < 3; i++)
      rd_chk(ofs[i], 32'h0, 2'h0);
    unit_access <= '0;
    cpu.xfer(RUN_GATE_OFS, 1'b1, 32'h0, q, r);
    cpu.xfer(CLK_CFG_OFS, 1'b1, 32'h0, q, r);
    irq_chk(IRQ_STATUS_OFS, 32'h3, 1'b0);
    for (int b = 0; b < 2; b++)
    begin
      irq_chk(IRQ_MASK_OFS, 32'h0, 1'b0);
      if (b == 0)
        unit_access <= '1;
      else
        power_mode <= PM_SLEEP;
      settle;
      unit_access <= '0;
      irq_chk(IRQ_MASK_OFS, 32'h1 << b, 1'b1);
      rd_chk(IRQ_STATUS_OFS, 32'h1 << b, 2'h0);
      rd_chk(FAULT_UNIT_OFS, 32'h3FF, 2'h0);
      irq_chk(IRQ_STATUS_OFS, 32'h1 << b, 1'b0);
    end
    cpu.be_sel = 4'h4;
    cpu.xfer(RUN_GATE_OFS, 1'b1, 32'hFFFFFFFF, q, r);
    cpu.be_sel = 4'hF;
    rd_chk(RUN_GATE_OFS, 32'h000F0000, 2'h0);
    cpu.xfer(12'h3F0, 1'b1, 32'hFFFFFFFF, q, r);
    chk("wr_response", {30'h0, r}, 32'h2);
    rd_chk(12'h3F0, 32'h0, 2'h2);
    summarize;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize;
  end
endmodule
